// ---- src/dsac_pkg.sv ----
package dsac_pkg;

   // Converter result width.
   localparam int DATA_W = 12;

   // Clock period in picoseconds (10 MHz).
   localparam int CLK_PS = 100000;

   // Times as printed, in nanoseconds.
   localparam int T_CONV_HS_NS  = 3600;
   localparam int T_CONV_AS_NS  = 6000;
   localparam int T_ACQ_NS      = 300;
   localparam int T_APERTURE_NS = 15;
   localparam int T_RD_GUARD_NS = 300;
   localparam int T_MIN_PERIOD_NS = 4000;

   // Cycle counts. Least times round up, at least one cycle.
   localparam int CYC_CONV_HS =
      (T_CONV_HS_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CYC_CONV_AS =
      (T_CONV_AS_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CYC_ACQ =
      (T_ACQ_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CYC_RD_GUARD =
      (T_RD_GUARD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CYC_MIN_PERIOD =
      (T_MIN_PERIOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // Aperture delay is shorter than one cycle, so hold starts one cycle
   // after the start edge is seen.
   localparam int CYC_APERTURE =
      ((T_APERTURE_NS * 1000 + CLK_PS - 1) / CLK_PS) < 1 ? 1 :
      (T_APERTURE_NS * 1000 + CLK_PS - 1) / CLK_PS;

   // Host strobe and start pulse length in cycles; a design choice.
   localparam int CYC_STROBE = 5;

   localparam int CNT_W = 8;

   // Device conversion states.
   typedef enum logic [1:0]
   {
      DSAC_TRACK   = 2'b00,
      DSAC_CONVERT = 2'b01,
      DSAC_SLEEP   = 2'b11
   } dsac_dev_state_t;

   // Host sequence states.
   typedef enum logic [2:0]
   {
      DSAC_H_IDLE  = 3'b000,
      DSAC_H_WAIT  = 3'b001,
      DSAC_H_START = 3'b011,
      DSAC_H_BUSY  = 3'b010,
      DSAC_H_RD1   = 3'b110,
      DSAC_H_GAP   = 3'b111,
      DSAC_H_RD2   = 3'b101
   } dsac_host_state_t;

endpackage

// ---- src/dsac_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dsac_if;
   import dsac_pkg::*;
   logic              conversion_start_n;
   logic              chip_select_n;
   logic              read_n;
   logic              input_pair_select;
   logic              busy;
   logic [DATA_W-1:0] data_out;
   logic              data_oe;

   modport device
   (
      input  conversion_start_n,
      input  chip_select_n,
      input  read_n,
      input  input_pair_select,
      output busy,
      output data_out,
      output data_oe
   );

   modport host
   (
      output conversion_start_n,
      output chip_select_n,
      output read_n,
      output input_pair_select,
      input  busy,
      input  data_out,
      input  data_oe
   );
endinterface
`default_nettype wire

// ---- src/dsac_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsac_sync
#(
   parameter int W = 1
)
(
   input  wire logic         i_mclk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   input  wire logic [W-1:0] i_reset_val,
   output logic      [W-1:0] o_sync
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dsac_sync_t;

   dsac_sync_t st_reg;
   dsac_sync_t st_next;

   initial
   begin
      if (W < 1)
      begin
         $error("dsac_sync width must be at least one");
      end
   end

   always_comb
   begin
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
   end

   // Each instance ties its reset value to the idle level of its start, strobe and busy pins, so
   // no false edge is seen when reset is released.
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st_reg.s1 <= i_reset_val;
         st_reg.s2 <= i_reset_val;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.s2;
endmodule
`default_nettype wire

// ---- src/dsac_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01 - Start falling edge holds both, starts conversion
// R02 - Busy falling marks both results ready
// R03 - First read input one, second input two
// R04 - Each result one 12-bit word, strobed
// R05 - Conversion 3.6 us fast, 6 us sleep
// R06 - Two modes; auto sleep after conversion
// R07 - Conversion timed by internal clock only
// R08 - Host avoids reads during conversion, 300 ns
// R09 - Host starts no faster than 250 kHz
// R10 - End of conversion returns to track, 0.3 us
// R11 - Host waits acquisition before next start
// R12 - Both holds taken together, matched aperture
// R13 - Four inputs in two pairs, select picks
// R14 - Busy high from start edge until done
// R15 - Data driven only while select and read low; data_oe follows the strobe pins three cycles late
// R16 - Read sequence restarts each start, advances
// R17 - Host holds pair select stable during read
module dsac_device
import dsac_pkg::*;
#(
   // Conversion and acquisition lengths in clock cycles.
   parameter int CONV_HS_CYCLES = CYC_CONV_HS,
   parameter int CONV_AS_CYCLES = CYC_CONV_AS,
   parameter int ACQ_CYCLES     = CYC_ACQ
)
(
   // Clock and reset.
   input  wire logic              i_mclk,
   input  wire logic              i_reset,
   // Mode: high for auto sleep.
   input  wire logic              i_auto_sleep,
   // Sampled analog values, already digitised by the analog front end.
   input  wire logic [DATA_W-1:0] i_pair_a_input_one,
   input  wire logic [DATA_W-1:0] i_pair_a_input_two,
   input  wire logic [DATA_W-1:0] i_pair_b_input_one,
   input  wire logic [DATA_W-1:0] i_pair_b_input_two,
   // Status toward the analog side.
   output logic                   o_hold,
   output logic                   o_sleep,
   output logic                   o_acquired,
   // Link.
   dsac_if.device                 link
);
   localparam logic [CNT_W-1:0] CONV_HS = CNT_W'(CONV_HS_CYCLES);
   localparam logic [CNT_W-1:0] CONV_AS = CNT_W'(CONV_AS_CYCLES);
   localparam logic [CNT_W-1:0] ACQ     = CNT_W'(ACQ_CYCLES);

   // Counts load the counters directly, so each must fit and be nonzero.
   initial
   begin
      if (CONV_HS_CYCLES < 1 || CONV_AS_CYCLES < 1)
      begin
         $error("conversion counts must be at least one");
      end
      if (CONV_HS_CYCLES >= (1 << CNT_W) || CONV_AS_CYCLES >= (1 << CNT_W))
      begin
         $error("conversion count does not fit counter");
      end
      if (ACQ_CYCLES < 1 || ACQ_CYCLES >= (1 << CNT_W))
      begin
         $error("acquisition count must fit and be at least one");
      end
   end

   // The sampled pair waits in the held words until busy falls, so a read
   // during conversion still returns the previous pair.

   typedef struct packed
   {
      dsac_dev_state_t   state;
      logic              start_prev;
      logic              read_prev;
      logic [CNT_W-1:0]  count;
      logic [CNT_W-1:0]  acq_count;
      logic              second;
      logic              auto_mode;
      logic              sleep;
      logic              hold;
      logic              busy;
      logic              acquired;
      logic [DATA_W-1:0] held_one;
      logic [DATA_W-1:0] held_two;
      logic [DATA_W-1:0] res_one;
      logic [DATA_W-1:0] res_two;
      logic [DATA_W-1:0] data;
      logic              oe;
   } dsac_dev_t;

   dsac_dev_t st_reg;
   dsac_dev_t st_next;

   logic [3:0] pins_sync;
   logic       start_n_s;
   logic       cs_n_s;
   logic       rd_n_s;
   logic       sel_s;
   logic       rd_active;

   // Every link pin passes two flops, so the start edge is acted on three
   // cycles after the pin falls; the host's waits allow for this lag.
   dsac_sync #(.W(4)) u_sync
   (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_async     ({link.conversion_start_n, link.chip_select_n,
                     link.read_n, link.input_pair_select}),
      .i_reset_val (4'hf),
      .o_sync      (pins_sync)
   );

   assign {start_n_s, cs_n_s, rd_n_s, sel_s} = pins_sync;
   assign rd_active = !cs_n_s && !rd_n_s;

   always_comb
   begin
      st_next            = st_reg;
      st_next.start_prev = start_n_s;
      st_next.read_prev  = rd_active;
      case (st_reg.state)
         DSAC_TRACK, DSAC_SLEEP:
         begin
            if (st_reg.acq_count != '0)
            begin
               st_next.acq_count = st_reg.acq_count - 1'b1; // see R10
            end
            // The flag rises as the last acquisition cycle ends, not later.
            if (st_reg.acq_count <= CNT_W'(1))
            begin
               st_next.acquired = 1'b1;
            end
            if (st_reg.start_prev && !start_n_s)
            begin
               // Both track/holds share one hold flop, so aperture matches.
               st_next.hold      = 1'b1; // see R01 R12
               st_next.busy      = 1'b1; // see R14
               st_next.held_one  = sel_s ? i_pair_b_input_one
                                         : i_pair_a_input_one; // see R13
               st_next.held_two  = sel_s ? i_pair_b_input_two
                                         : i_pair_a_input_two; // see R13
               st_next.second    = 1'b0; // see R16
               st_next.acquired  = 1'b0;
               st_next.sleep     = 1'b0; // see R06
               // Mode is latched so a change mid-conversion cannot split it.
               st_next.auto_mode = i_auto_sleep;
               st_next.count     = i_auto_sleep ? CONV_AS : CONV_HS; // see R05
               st_next.state     = DSAC_CONVERT;
            end
         end
         DSAC_CONVERT:
         begin
            // Timed by the local clock; the host supplies none.
            st_next.count = st_reg.count - 1'b1; // see R07
            if (st_reg.count == CNT_W'(1))
            begin
               // Results become readable only now, as busy falls.
               st_next.res_one   = st_reg.held_one; // see R02
               st_next.res_two   = st_reg.held_two;
               st_next.busy      = 1'b0; // see R02 R14
               st_next.hold      = 1'b0; // see R10
               st_next.acq_count = ACQ;
               st_next.sleep     = st_reg.auto_mode; // see R06
               st_next.state     = st_reg.auto_mode ? DSAC_SLEEP
                                                    : DSAC_TRACK; // see R06
            end
         end
         default:
         begin
            st_next.state = DSAC_TRACK;
         end
      endcase
      // Output word follows the strobes; host keeps select steady (R17).
      st_next.oe   = rd_active; // see R15
      st_next.data = st_reg.second ? st_reg.res_two
                                   : st_reg.res_one; // see R03 R04
      if (st_reg.read_prev && !rd_active)
      begin
         st_next.second = 1'b1; // see R16
      end
      if (st_reg.state != DSAC_CONVERT && st_reg.start_prev && !start_n_s)
      begin
         st_next.second = 1'b0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st_reg            <= '0;
         st_reg.state      <= DSAC_TRACK;
         st_reg.start_prev <= 1'b1;
         st_reg.acquired   <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign link.busy     = st_reg.busy;
   assign link.data_out = st_reg.data;
   assign link.data_oe  = st_reg.oe;
   assign o_hold        = st_reg.hold;
   assign o_sleep       = st_reg.sleep;
   assign o_acquired    = st_reg.acquired;
endmodule
`default_nettype wire

// ---- src/dsac_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsac_host
import dsac_pkg::*;
(
   // Clock and reset.
   input  wire logic              i_mclk,
   input  wire logic              i_reset,
   // User request.
   input  wire logic              i_request,
   input  wire logic              i_pair_b,
   // User results.
   output logic                   o_valid,
   output logic [DATA_W-1:0]      o_result_one,
   output logic [DATA_W-1:0]      o_result_two,
   output logic                   o_ready,
   // Link.
   dsac_if.host                   link
);
   localparam logic [CNT_W-1:0] PERIOD = CNT_W'(CYC_MIN_PERIOD);
   localparam logic [CNT_W-1:0] ACQ    = CNT_W'(CYC_ACQ + CYC_RD_GUARD);
   // The strobe counter runs down to zero, so it loads one less than the span.
   localparam logic [CNT_W-1:0] STROBE = CNT_W'(CYC_STROBE - 1);

   typedef struct packed
   {
      dsac_host_state_t  state;
      logic [CNT_W-1:0]  count;
      logic [CNT_W-1:0]  period;
      logic              start_n;
      logic              cs_n;
      logic              rd_n;
      logic              sel;
      logic              valid;
      logic              ready;
      logic [DATA_W-1:0] one;
      logic [DATA_W-1:0] two;
   } dsac_host_st_t;

   dsac_host_st_t st_reg;
   dsac_host_st_t st_next;
   logic          busy_s;
   logic [DATA_W-1:0] data_s;

   dsac_sync #(.W(DATA_W + 1)) u_sync
   (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_async     ({link.busy, link.data_out}),
      .i_reset_val ('0),
      .o_sync      ({busy_s, data_s})
   );

   always_comb
   begin
      st_next       = st_reg;
      st_next.valid = 1'b0;
      if (st_reg.period != '0)
      begin
         st_next.period = st_reg.period - 1'b1; // see R09
      end
      if (st_reg.count != '0)
      begin
         st_next.count = st_reg.count - 1'b1;
      end
      case (st_reg.state)
         DSAC_H_IDLE:
         begin
            st_next.ready = (st_reg.period == '0) && (st_reg.count == '0);
            if (st_reg.ready && i_request)
            begin
               st_next.ready   = 1'b0;
               st_next.sel     = i_pair_b;
               st_next.count   = ACQ; // see R11
               st_next.state   = DSAC_H_WAIT;
            end
         end
         DSAC_H_WAIT:
         begin
            if (st_reg.count == '0)
            begin
               st_next.start_n = 1'b0; // see R01
               st_next.period  = PERIOD;
               st_next.count   = STROBE;
               st_next.state   = DSAC_H_START;
            end
         end
         DSAC_H_START:
         begin
            if (st_reg.count == '0)
            begin
               st_next.start_n = 1'b1;
               st_next.state   = DSAC_H_BUSY;
            end
         end
         DSAC_H_BUSY:
         begin
            // No strobes until busy drops.
            if (!busy_s && st_reg.start_n)
            begin
               st_next.cs_n  = 1'b0; // see R08
               st_next.rd_n  = 1'b0;
               st_next.count = STROBE;
               st_next.state = DSAC_H_RD1;
            end
         end
         DSAC_H_RD1:
         begin
            if (st_reg.count == '0)
            begin
               st_next.one   = data_s; // see R03
               st_next.cs_n  = 1'b1;
               st_next.rd_n  = 1'b1;
               st_next.count = STROBE;
               st_next.state = DSAC_H_GAP;
            end
         end
         DSAC_H_GAP:
         begin
            if (st_reg.count == '0)
            begin
               st_next.cs_n  = 1'b0;
               st_next.rd_n  = 1'b0;
               st_next.count = STROBE;
               st_next.state = DSAC_H_RD2;
            end
         end
         DSAC_H_RD2:
         begin
            if (st_reg.count == '0)
            begin
               st_next.two   = data_s; // see R04
               st_next.cs_n  = 1'b1;
               st_next.rd_n  = 1'b1;
               st_next.valid = 1'b1;
               st_next.count = ACQ; // see R11
               st_next.state = DSAC_H_IDLE;
            end
         end
         default:
         begin
            st_next.state = DSAC_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st_reg         <= '0;
         st_reg.state   <= DSAC_H_IDLE;
         st_reg.start_n <= 1'b1;
         st_reg.cs_n    <= 1'b1;
         st_reg.rd_n    <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Select is held for the whole job, so it is steady in every strobe.
   assign link.input_pair_select  = st_reg.sel; // see R17
   assign link.conversion_start_n = st_reg.start_n;
   assign link.chip_select_n      = st_reg.cs_n;
   assign link.read_n             = st_reg.rd_n;
   assign o_valid      = st_reg.valid;
   assign o_result_one = st_reg.one;
   assign o_result_two = st_reg.two;
   assign o_ready      = st_reg.ready;
endmodule
`default_nettype wire

// ---- tb/dsac_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsac_props
import dsac_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_reset,
   input wire logic              conversion_start_n,
   input wire logic              chip_select_n,
   input wire logic              read_n,
   input wire logic              input_pair_select,
   input wire logic              busy,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe
);
   // Long spans are counted here because repetition is kept short.
   logic [7:0] busy_cnt_reg;
   logic [7:0] gap_cnt_reg;
   logic       start_q_reg;
   logic       start_fell;
   assign start_fell = start_q_reg && !conversion_start_n;
   always_ff @(posedge i_mclk)
   begin
      start_q_reg <= conversion_start_n;
      if (i_reset)
      begin
         busy_cnt_reg <= 8'h00;
         gap_cnt_reg  <= 8'hff;
      end
      else
      begin
         busy_cnt_reg <= busy ? busy_cnt_reg + 8'h01 : 8'h00;
         if (start_fell)
            gap_cnt_reg <= 8'h01;
         else if (gap_cnt_reg != 8'hff)
            gap_cnt_reg <= gap_cnt_reg + 8'h01;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   property p_busy_start;
      $fell(conversion_start_n) && !busy |-> ##[2:4] $rose(busy);
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy did not follow the start edge");
   property p_busy_len;
      $fell(busy) |-> busy_cnt_reg == CYC_CONV_HS ||
                      busy_cnt_reg == CYC_CONV_AS;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("conversion length is wrong");
   property p_period;
      start_fell |-> gap_cnt_reg >= CYC_MIN_PERIOD;
   endproperty
   a_period: assert property (p_period)
      else $error("starts come too close together");
   property p_acq;
      $fell(busy) |-> conversion_start_n [*6];
   endproperty
   a_acq: assert property (p_acq)
      else $error("start came before acquisition ended");
   property p_no_read;
      busy |-> read_n;
   endproperty
   a_no_read: assert property (p_no_read)
      else $error("read strobe during conversion");
   property p_oe_off;
      (chip_select_n || read_n) [*6] |-> !data_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data driven without strobes");
   property p_oe_on;
      $fell(read_n) && !chip_select_n |-> ##[3:5] data_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("data not driven during read");
   property p_sel;
      !read_n && !$fell(read_n) |-> $stable(input_pair_select);
   endproperty
   a_sel: assert property (p_sel)
      else $error("pair select moved during read");
endmodule
`default_nettype wire

// ---- tb/dual_sim_sample_adc_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_sim_sample_adc_control_tb;
   import dsac_pkg::*;
   logic              i_mclk = 1'b0;
   logic              i_reset = 1'b1;
   logic              auto_sleep = 1'b0;
   logic              request = 1'b0;
   logic              pair_b = 1'b0;
   logic [DATA_W-1:0] in_v [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
   logic              hold, sleep, acquired, valid, ready;
   logic [DATA_W-1:0] res_one, res_two;
   integer            seed = 32'h5082;
   integer            fails = 0;
   integer            n_tests = 0;
   integer            cycles = 0;
   int                exp_q [$];
   dsac_if link_if ();
   dsac_device u_dsac_device (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_auto_sleep(auto_sleep), .i_pair_a_input_one(in_v[0]),
      .i_pair_a_input_two(in_v[1]), .i_pair_b_input_one(in_v[2]),
      .i_pair_b_input_two(in_v[3]), .o_hold(hold), .o_sleep(sleep),
      .o_acquired(acquired), .link(link_if.device));
   dsac_host u_dsac_host (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_request(request), .i_pair_b(pair_b), .o_valid(valid),
      .o_result_one(res_one), .o_result_two(res_two), .o_ready(ready),
      .link(link_if.host));
   dsac_props u_dsac_props (.i_mclk(i_mclk), .i_reset(i_reset),
      .conversion_start_n(link_if.conversion_start_n),
      .chip_select_n(link_if.chip_select_n), .read_n(link_if.read_n),
      .input_pair_select(link_if.input_pair_select),
      .busy(link_if.busy), .data_out(link_if.data_out),
      .data_oe(link_if.data_oe));
   always #50 i_mclk = ~i_mclk;
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // A runaway wait ends the run rather than hanging the simulator.
   always @(posedge i_mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         test_done();
      end
   end
   task automatic check(input logic [DATA_W-1:0] got,
                        input logic [DATA_W-1:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Signals are picked by number so the wait needs no reference argument.
   function automatic logic pick(input int which);
      case (which)
         0: return ready;
         1: return link_if.busy;
         default: return valid;
      endcase
   endfunction
   task automatic wait_for(input int which, input logic lvl);
      int n;
      n = 0;
      while (pick(which) !== lvl && n < 200)
      begin
         @(negedge i_mclk);
         n = n + 1;
      end
      check({11'h000, pick(which)}, {11'h000, lvl});
   endtask
   // One full conversion and read pair with fresh random inputs.
   task automatic run_one();
      int cnt;
      int r;
      wait_for(0, 1'b1);
      r = $random(seed);
      pair_b = r[0];
      r = $random(seed);
      auto_sleep = r[0];
      for (int k = 0; k < 4; k++)
      begin
         r = $random(seed);
         in_v[k] = r[DATA_W-1:0];
      end
      exp_q.push_back(pair_b ? in_v[2] : in_v[0]);
      exp_q.push_back(pair_b ? in_v[3] : in_v[1]);
      exp_q.push_back(auto_sleep ? CYC_CONV_AS : CYC_CONV_HS);
      request = 1'b1;
      @(negedge i_mclk);
      request = 1'b0;
      wait_for(1, 1'b1);
      check({11'h000, hold}, 12'h001);
      cnt = 0;
      while (link_if.busy === 1'b1 && cnt < 100)
      begin
         check({11'h000, acquired}, 12'h000);
         @(negedge i_mclk);
         cnt = cnt + 1;
      end
      // Acquisition takes CYC_ACQ cycles from the fall of busy.
      for (int k = 0; k < CYC_ACQ; k++)
      begin
         check({11'h000, acquired}, 12'h000);
         @(negedge i_mclk);
      end
      check({11'h000, acquired}, 12'h001);
      wait_for(2, 1'b1);
      check(res_one, DATA_W'(exp_q.pop_front()));
      check(res_two, DATA_W'(exp_q.pop_front()));
      check(DATA_W'(cnt), DATA_W'(exp_q.pop_front()));
      check({11'h000, sleep}, {11'h000, auto_sleep});
      check({11'h000, hold}, 12'h000);
   endtask
   initial
   begin
      repeat (2) @(negedge i_mclk);
      i_reset = 1'b0;
      for (int i = 0; i < 20; i++)
         run_one();
      // A reset in mid-conversion must leave the link quiet and usable.
      wait_for(0, 1'b1);
      request = 1'b1;
      @(negedge i_mclk);
      request = 1'b0;
      wait_for(1, 1'b1);
      i_reset = 1'b1;
      repeat (2) @(negedge i_mclk);
      check({9'h000, hold, link_if.busy, link_if.data_oe}, 12'h000);
      i_reset = 1'b0;
      for (int i = 0; i < 4; i++)
         run_one();
      test_done();
   end
endmodule
`default_nettype wire
